// file: prog_model.sv
// programmer model: serial clock, data line and mode level
module prog_model (
  input  wire logic clk,
  input  wire logic dev_oe,
  input  wire logic dev_out,
  output logic      sclk,
  output logic      line,
  output logic      mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_oe  = 1'b1;
  logic m_val = 1'b0;
  logic flt   = 1'b0;
  // a released line toggles so a stale level can never pass
  always @(posedge clk) flt <= ~flt;
  assign line = dev_oe ? dev_out : (m_oe ? m_val : flt);
  initial begin
    sclk = 1'b0;
    mode = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one serial cycle of 160 ns; read bit taken late in the low phase
  task automatic cyc(input logic v, output logic rd);
    @(posedge clk);
    sclk  <= 1'b1;
    m_val <= v;
    repeat (4) @(posedge clk);
    sclk <= 1'b0;
    repeat (3) @(posedge clk);
    rd = line;
  endtask
  // mode change with clock and data held low
  task automatic set_mode(input logic v);
    @(posedge clk);
    m_val <= 1'b0;
    mode  <= v;
    repeat (20) @(posedge clk);
  endtask
  task automatic send(input logic [5:0] c);
    logic r;
    for (int i = 0; i < 6; i++) cyc(c[i], r);
    repeat (60) @(posedge clk);
  endtask
  // start, 14 bits lsb first, stop; line released for reads
  task automatic frame(input logic [13:0] w, input logic rd_en, output logic [13:0] got);
    logic r;
    m_oe <= ~rd_en;
    cyc(1'b0, r);
    for (int i = 0; i < 14; i++) begin
      cyc(w[i], r);
      got[i] = r;
    end
    cyc(1'b0, r);
    m_oe <= 1'b1;
    repeat (60) @(posedge clk);
  endtask
endmodule

// file: serprog_pkg.sv
// types shared by the serial program/verify port
package serprog_pkg;
  typedef enum logic [2:0] {
    OP_LOAD_CFG  = 3'h0,
    OP_LOAD_DATA = 3'h1,
    OP_READ      = 3'h2,
    OP_INCR      = 3'h3,
    OP_BEGIN     = 3'h4,
    OP_END       = 3'h7
  } op_t;
  typedef struct packed {
    logic        we;
    logic        cfg;
    logic [13:0] addr;
    logic [13:0] wdata;
  } prog_req_t;
endpackage

// file: serprog_port.sv
// serial program/verify port: command shifter, counter, data frames
`include "serprog_regs.svh"
module serprog_port (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PROG_MODE,
  input  wire logic        SCLK_PIN,
  input  wire logic        SDATA_IN,
  output logic             SDATA_OUT,
  output logic             SDATA_OE,
  output logic [13:0]      MEM_ADDR,
  output logic             MEM_CFG,
  output logic [13:0]      MEM_WDATA,
  output logic             MEM_PROG,
  input  wire logic [13:0] MEM_RDATA
);
  typedef enum logic [1:0] {S_CMD, S_LOAD, S_READ} phase_t;
  ////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage feeds only the second
  logic [1:0] clk_s_q, dat_s_q, mode_s_q;
  logic       clk_prev_q;
  always_ff @(posedge CLK) begin
    if (RST) begin
      clk_s_q    <= 2'h0;
      dat_s_q    <= 2'h0;
      mode_s_q   <= 2'h0;
      clk_prev_q <= 1'b0;
    end else begin
      clk_s_q    <= {clk_s_q[0], SCLK_PIN};
      dat_s_q    <= {dat_s_q[0], SDATA_IN};
      mode_s_q   <= {mode_s_q[0], PROG_MODE};
      clk_prev_q <= clk_s_q[1];
    end
  end
  logic rise, fall, mode;
  assign rise = clk_s_q[1] && !clk_prev_q;
  assign fall = !clk_s_q[1] && clk_prev_q;
  assign mode = mode_s_q[1];
  ////////////////////////////////////////////////////////////////////////
  // next-address function for increment, keeping the config bit set once in config space
  function automatic logic [13:0] next_pc(input logic [13:0] pc);
    logic [13:0] n;
    n = pc + 14'h0001;
    if (pc[13]) n[13] = 1'b1;
    return n;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // fifo between captured frames and the write path
  logic        fifo_ready, fifo_valid;
  logic [13:0] fifo_data;
  logic        push_d, push_q;
  logic [13:0] word_d, word_q;
  word_fifo #(.WIDTH(`WORD_BITS), .DEPTH(4)) u_fifo (
    .clk      (CLK),
    .rst      (RST),
    .in_valid (push_q),
    .in_ready (fifo_ready),
    .in_data  (word_q),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data (fifo_data)
  );
  ////////////////////////////////////////////////////////////////////////
  // protocol state
  phase_t      ph_q, ph_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [5:0]  sh_q, sh_d;
  logic [13:0] pc_q, pc_d;
  logic [13:0] ld_q, ld_d;
  logic [13:0] rd_q, rd_d;
  logic        oe_q, oe_d, out_q, out_d, prog_q, prog_d;
  serprog_pkg::prog_req_t req;
  serprog_pkg::op_t       op;
  assign op = serprog_pkg::op_t'(sh_d[3:1]);
  always_comb begin
    ph_d = ph_q; cnt_d = cnt_q; sh_d = sh_q; pc_d = pc_q; ld_d = ld_q;
    rd_d = rd_q; oe_d = oe_q; out_d = out_q; prog_d = prog_q;
    push_d = 1'b0; word_d = word_q;
    if (fifo_valid) ld_d = fifo_data;  // loaded word lands after fifo
    if (!mode) begin
      // leaving mode resets counter: only exit back to user space
      ph_d = S_CMD; cnt_d = 5'h00; pc_d = 14'h0000;
      oe_d = 1'b0; prog_d = 1'b0;
    end else begin
      unique case (ph_q)
        S_CMD: if (fall) begin
          sh_d  = {dat_s_q[1], sh_q[5:1]};  // lsb first
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == 5'(`CMD_BITS - 1)) begin
            cnt_d = 5'h00;
            unique case (op)
              serprog_pkg::OP_LOAD_CFG: begin
                pc_d = `CFG_BASE; ph_d = S_LOAD;
              end
              serprog_pkg::OP_LOAD_DATA: ph_d = S_LOAD;
              serprog_pkg::OP_READ: begin
                ph_d = S_READ; rd_d = MEM_RDATA;
              end
              serprog_pkg::OP_INCR: pc_d = next_pc(pc_q);
              serprog_pkg::OP_BEGIN: prog_d = 1'b1;
              serprog_pkg::OP_END: prog_d = 1'b0;
              default: ;
            endcase
          end
        end
        S_LOAD: if (fall) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q >= 5'h01 && cnt_q <= 5'(`WORD_BITS))
            word_d = {dat_s_q[1], word_q[13:1]};
          if (cnt_q == 5'(`FRAME_CYCLES - 1)) begin
            ph_d = S_CMD; cnt_d = 5'h00;
            push_d = fifo_ready;  // full fifo drops the word
          end
        end
        S_READ: begin
          if (rise) begin
            // drive from second to sixteenth rising edge
            if (cnt_q >= 5'h01 && cnt_q <= 5'(`WORD_BITS)) begin
              oe_d = 1'b1;
              out_d = rd_q[0];
              rd_d = {1'b0, rd_q[13:1]};
            end else if (cnt_q == 5'(`WORD_BITS + 1)) begin
              oe_d = 1'b1;
              out_d = 1'b0;  // stop bit
            end
          end
          if (fall) begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == 5'(`FRAME_CYCLES - 1)) begin
              ph_d = S_CMD; cnt_d = 5'h00; oe_d = 1'b0;
            end
          end
        end
        default: ph_d = S_CMD;
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      ph_q <= S_CMD; cnt_q <= 5'h00; sh_q <= 6'h00; pc_q <= 14'h0000;
      ld_q <= 14'h0000; rd_q <= 14'h0000; oe_q <= 1'b0; out_q <= 1'b0;
      prog_q <= 1'b0; push_q <= 1'b0; word_q <= 14'h0000;
    end else begin
      ph_q <= ph_d; cnt_q <= cnt_d; sh_q <= sh_d; pc_q <= pc_d;
      ld_q <= ld_d; rd_q <= rd_d; oe_q <= oe_d; out_q <= out_d;
      prog_q <= prog_d; push_q <= push_d; word_q <= word_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // memory-side outputs, all registered
  always_comb begin
    req.we    = prog_q;
    req.cfg   = pc_q[13];
    // user space uses 10 bits; config aliases in 2000h-23FFh
    req.addr  = pc_q[13] ? (`CFG_BASE | (pc_q & `CFG_ALIAS_MASK))
                         : {4'h0, pc_q[`USER_ADDR_BITS-1:0]};
    req.wdata = ld_q;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      MEM_ADDR <= 14'h0000; MEM_CFG <= 1'b0; MEM_WDATA <= 14'h0000;
      MEM_PROG <= 1'b0; SDATA_OUT <= 1'b0; SDATA_OE <= 1'b0;
    end else begin
      MEM_ADDR <= req.addr; MEM_CFG <= req.cfg; MEM_WDATA <= req.wdata;
      MEM_PROG <= req.we; SDATA_OUT <= out_q; SDATA_OE <= oe_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  cfg_sticky_a: assert property (@(posedge CLK) disable iff (RST)
    (mode && pc_q[13]) |=> (!mode || pc_q[13]))
    else $error("config bit dropped");
  user_addr_a: assert property (@(posedge CLK) disable iff (RST)
    !pc_q[13] |=> MEM_ADDR[13:10] == 4'h0)
    else $error("user address above 3FF");
  cfg_alias_a: assert property (@(posedge CLK) disable iff (RST)
    pc_q[13] |=> MEM_ADDR[13:10] == 4'h8)
    else $error("config alias wrong");
  ldcfg_pc_a: assert property (@(posedge CLK) disable iff (RST)
    (mode && ph_q == S_CMD && fall && cnt_q == 5'h05 && sh_d[3:1] == 3'h0)
    |=> pc_q == 14'h2000)
    else $error("load config did not set 2000h");
  incr_a: assert property (@(posedge CLK) disable iff (RST)
    (mode && ph_q == S_CMD && fall && cnt_q == 5'h05 && sh_d[3:1] == 3'h3
     && !pc_q[13]) |=> pc_q == $past(pc_q) + 14'h0001)
    else $error("increment wrong");
  prog_on_a: assert property (@(posedge CLK) disable iff (RST)
    (mode && ph_q == S_CMD && fall && cnt_q == 5'h05 && sh_d[3:1] == 3'h4)
    |=> ##1 MEM_PROG)
    else $error("programming not started");
  prog_off_a: assert property (@(posedge CLK) disable iff (RST)
    (mode && ph_q == S_CMD && fall && cnt_q == 5'h05 && sh_d[3:1] == 3'h7)
    |=> ##1 !MEM_PROG)
    else $error("programming not stopped");
  oe_cmd_a: assert property (@(posedge CLK) disable iff (RST)
    (ph_q != S_READ) |=> ##1 !SDATA_OE)
    else $error("data pin driven outside read");
  nop_a: assert property (@(posedge CLK) disable iff (RST)
    (mode && ph_q == S_CMD && fall && cnt_q == 5'h05 &&
     (sh_d[3:1] == 3'h5 || sh_d[3:1] == 3'h6)) |=> $stable(pc_q) && ph_q == S_CMD)
    else $error("undefined command had effect");
  read_c: cover property (@(posedge CLK) ph_q == S_READ ##1 ph_q == S_CMD);
  load_c: cover property (@(posedge CLK) push_q);
  cfg_c: cover property (@(posedge CLK) pc_q[13] && MEM_PROG);
endmodule

// file: serprog_regs.svh
// constants for the serial program/verify port
`ifndef SERPROG_REGS_SVH
`define SERPROG_REGS_SVH
`define CMD_BITS        6
`define FRAME_CYCLES    16
`define WORD_BITS       14
`define USER_ADDR_BITS  10
`define CFG_BASE        14'h2000
`define CFG_ALIAS_MASK  14'h03FF
`define PULSE_TIME_US   100
`define CLK_MHZ         50
`endif

// file: tb.sv
// testbench: port with programmer model, memory stand-in, fifo checks
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        sclk, line, mode, oe, dout, cfg, prog;
  logic [13:0] addr, wdata, rdata, got;
  int          fail_count = 0;
  int          comparisons = 0;
  always #10 CLK = ~CLK;
  // memory stand-in: arbitrary pattern of the address
  assign rdata = addr ^ 14'h1555;
  serprog_port serprog_port_inst (.CLK(CLK), .RST(RST), .PROG_MODE(mode), .SCLK_PIN(sclk),
    .SDATA_IN(line), .SDATA_OUT(dout), .SDATA_OE(oe), .MEM_ADDR(addr), .MEM_CFG(cfg),
    .MEM_WDATA(wdata), .MEM_PROG(prog), .MEM_RDATA(rdata));
  prog_model prog_model_inst (.clk(CLK), .dev_oe(oe), .dev_out(dout), .sclk(sclk),
    .line(line), .mode(mode));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // don't-care command bits set to ones on purpose
  task automatic cmd(input logic [2:0] op);
    prog_model_inst.send({2'h3, op, 1'b1});
    repeat (10) @(posedge CLK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // load, long write pulse, stray codes, end
  task automatic t_load_prog();
    prog_model_inst.set_mode(1'b1);
    cmd(serprog_pkg::OP_LOAD_DATA);
    prog_model_inst.frame(14'h1A5C, 1'b0, got);
    repeat (10) @(posedge CLK);
    chk("loaded word", 14'h1A5C, wdata);
    cmd(serprog_pkg::OP_BEGIN);
    repeat (5000) @(posedge CLK);
    chk("pulse on", 14'h1, {13'h0, prog});
    cmd(3'h5);
    cmd(3'h6);
    chk("undefined op", 14'h1, {oe, addr[11:0], prog});
    chk("undefined word", 14'h1A5C, wdata);
    cmd(serprog_pkg::OP_END);
    chk("pulse off", 14'h0, {13'h0, prog});
  endtask
  // step the counter, read back, line released after the frame
  task automatic t_read();
    for (int i = 0; i < 3; i++) cmd(serprog_pkg::OP_INCR);
    chk("user addr", 14'h3, addr);
    cmd(serprog_pkg::OP_READ);
    prog_model_inst.frame(14'h0, 1'b1, got);
    chk("read word", 14'h3 ^ 14'h1555, got);
    chk("drive off", 14'h0, {13'h0, oe});
  endtask
  // config space entry, alias read, exit back to user space
  task automatic t_config();
    cmd(serprog_pkg::OP_LOAD_CFG);
    prog_model_inst.frame(14'h0123, 1'b0, got);
    repeat (10) @(posedge CLK);
    chk("cfg addr", 14'h2000, addr);
    chk("cfg word", 14'h0123, wdata);
    cmd(serprog_pkg::OP_INCR);
    chk("cfg step", 14'h2001, addr);
    chk("cfg held", 14'h1, {13'h0, cfg});
    cmd(serprog_pkg::OP_READ);
    prog_model_inst.frame(14'h0, 1'b1, got);
    chk("cfg read", 14'h2001 ^ 14'h1555, got);
    prog_model_inst.set_mode(1'b0);
    prog_model_inst.set_mode(1'b1);
    chk("re-entry", 14'h0, {cfg, addr[12:0]});
  endtask
  // back-to-back loads pass the fifo in order through the port, then it drains
  task automatic t_fifo();
    cmd(serprog_pkg::OP_LOAD_DATA);
    prog_model_inst.frame(14'h0AAA, 1'b0, got);
    chk("fifo space", 14'h1, {13'h0, serprog_port_inst.fifo_ready});
    chk("fifo word", 14'h0AAA, wdata);
    cmd(serprog_pkg::OP_LOAD_DATA);
    prog_model_inst.frame(14'h3555, 1'b0, got);
    repeat (10) @(posedge CLK);
    chk("fifo word", 14'h3555, wdata);
    chk("fifo empty", 14'h0, {13'h0, serprog_port_inst.fifo_valid});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    chk("reset state", 14'h0, {oe, cfg, prog, addr[10:0]});
    t_load_prog();
    t_read();
    t_config();
    t_fifo();
    end_of_test();
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge CLK);
    fail_count++;
    end_of_test();
  end
endmodule

// file: word_fifo.sv
// small valid/ready fifo for data words
module word_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q, rp_q;
  logic             push, pop;
  // honest full and empty from pointer difference
  assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
    if (push) mem[wp_q[AW-1:0]] <= in_data;
  end
endmodule
